// *** rtl/can_tx_abort_select.sv ***
/*
 * Transmit-side abort handling and buffer selection of a CAN controller
 * with three transmit buffers: empty flags, empty interrupt enables,
 * abort request / acknowledge and buffer select, on classic Wishbone.
 * Assumes the protocol engine reports per buffer when a frame starts,
 * completes, or fails, and that init mode signals come from the controller.
 */
`timescale 1ns/1ns
`default_nettype none
module can_tx_abort_select #(
   parameter int NB = can_tx_pkg::NUM_BUF
) (
   input  wire logic          clk_i,                   // 100 MHz clock
   input  wire logic          rst_i,                   // Sync reset, active high
   input  wire logic          wb_cyc_i,                // Wishbone cycle
   input  wire logic          wb_stb_i,                // Wishbone strobe
   input  wire logic          wb_we_i,                 // Wishbone write
   input  wire logic [7:0]    wb_adr_i,                // Byte address
   input  wire logic [3:0]    wb_sel_i,                // Byte selects
   input  wire logic [31:0]   wb_dat_i,                // Write data
   output logic      [31:0]   wb_dat_o,                // Read data
   output logic               wb_ack_o,                // Acknowledge
   input  wire logic          init_mode_request,       // Init request level
   input  wire logic          init_mode_acknowledge,   // Init acknowledge level
   input  wire logic [NB-1:0] tx_started_i,            // Frame on bus, one pulse per buffer
   input  wire logic [NB-1:0] tx_done_i,               // Frame sent successfully
   input  wire logic [NB-1:0] tx_failed_i,             // Lost arbitration or error
   input  wire logic          win_req_i,               // CPU access to transmit window
   output logic               win_allow_o,             // Window access permitted
   output logic      [NB-1:0] win_buf_o,               // One-hot buffer in window
   output logic      [NB-1:0] scheduled_o,             // Buffers queued for engine
   output logic      [NB-1:0] irq_status_o,            // Sticky empty-event status
   output logic               irq_o                    // Interrupt level
);
   logic          init_active;
   logic          run_mode;
   logic          wr;
   logic          rd;
   logic [7:0]    wr_byte;
   logic [NB-1:0] wr_bits;
   logic [NB-1:0] buffer_empty_flags;
   logic [NB-1:0] buffer_empty_irq_enable;
   logic [NB-1:0] abort_request_bits;
   logic [NB-1:0] abort_acknowledge_bits;
   logic [NB-1:0] tx_buffer_select;
   logic [NB-1:0] sel_pick;
   logic [NB-1:0] in_flight;
   logic [NB-1:0] grant;
   logic [NB-1:0] next_empty;
   logic [NB-1:0] empty_event;
   logic [NB-1:0] irq_clear;
   logic [NB-1:0] irq_enable;
   logic          irq_level;

   assign init_active = init_mode_request & init_mode_acknowledge;
   assign run_mode    = ~init_mode_request & ~init_mode_acknowledge;
   assign wr          = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd          = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign wr_byte     = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
   assign wr_bits     = wr_byte[NB-1:0];

   function automatic logic hit(input logic [7:0] ofs);
      hit = wr & (wb_adr_i == ofs);
   endfunction

   // Frame on the wire, not yet resolved; an abort must wait for the outcome
   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         in_flight <= '0;
      end else begin
         in_flight <= (in_flight | tx_started_i) & ~tx_done_i & ~tx_failed_i;
      end
   end

   assign grant = abort_request_bits & ~buffer_empty_flags & ~in_flight & ~tx_started_i;

   always_comb begin
      next_empty = buffer_empty_flags | tx_done_i | grant;
      if (hit(can_tx_pkg::OFS_FLAG) && run_mode) begin
         // Write one clears: software hands the buffer to the engine
         next_empty = next_empty & ~(wr_bits & ~tx_done_i & ~grant);
      end
   end

   assign empty_event = next_empty & ~buffer_empty_flags;

   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         buffer_empty_flags <= can_tx_pkg::FLAG_RESET;
      end else begin
         buffer_empty_flags <= next_empty;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         buffer_empty_irq_enable <= can_tx_pkg::ZERO_RESET;
      end else if (hit(can_tx_pkg::OFS_IRQ_EN) && run_mode) begin
         buffer_empty_irq_enable <= wr_bits;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         abort_request_bits <= can_tx_pkg::ZERO_RESET;
      end else begin
         // Cleared once the buffer is empty; a 1 on an empty buffer drops out
         abort_request_bits <= (abort_request_bits
                                | ((hit(can_tx_pkg::OFS_ABORT_REQ) && run_mode) ? wr_bits : '0))
                               & ~next_empty & ~buffer_empty_flags;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         abort_acknowledge_bits <= can_tx_pkg::ZERO_RESET;
      end else begin
         abort_acknowledge_bits <= (abort_acknowledge_bits | grant) & next_empty;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || init_active) begin
         tx_buffer_select <= can_tx_pkg::ZERO_RESET;
      end else if (hit(can_tx_pkg::OFS_BUF_SEL) && run_mode) begin
         tx_buffer_select <= sel_pick;
      end
   end

   logic [NB-1:0] wr_pick;
   lowest_bit_pick #(.W(NB)) u_pick (
      .vec_i  (wr_bits),
      .pick_o (wr_pick)
   );
   assign sel_pick = wr_pick;

   // Window gate is registered so the port comes from a flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_allow_o <= 1'b0;
         win_buf_o   <= '0;
         scheduled_o <= '0;
      end else begin
         win_buf_o   <= tx_buffer_select;
         win_allow_o <= win_req_i & (|tx_buffer_select)
                        & ~(|(tx_buffer_select & ~buffer_empty_flags));
         scheduled_o <= ~buffer_empty_flags;
      end
   end

   assign irq_clear  = hit(can_tx_pkg::OFS_IRQ_CLEAR) ? wr_bits : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_enable <= '0;
      end else if (hit(can_tx_pkg::OFS_IRQ_ENABLE)) begin
         irq_enable <= wr_bits;
      end
   end

   event_irq #(.W(NB)) u_irq (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .event_i  (empty_event & buffer_empty_irq_enable),
      .clear_i  (irq_clear),
      .enable_i (irq_enable),
      .status_o (irq_status_o),
      .irq_o    (irq_level)
   );
   assign irq_o = irq_level;

   function automatic logic [31:0] widen(input logic [NB-1:0] v);
      widen = {{(32-NB){1'b0}}, v};
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= can_tx_pkg::UNMAPPED_DATA;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (rd) begin
            unique case (wb_adr_i)
               can_tx_pkg::OFS_FLAG:       wb_dat_o <= widen(buffer_empty_flags);
               can_tx_pkg::OFS_IRQ_EN:     wb_dat_o <= widen(buffer_empty_irq_enable);
               can_tx_pkg::OFS_ABORT_REQ:  wb_dat_o <= widen(abort_request_bits);
               can_tx_pkg::OFS_ABORT_ACK:  wb_dat_o <= widen(abort_acknowledge_bits);
               can_tx_pkg::OFS_BUF_SEL:    wb_dat_o <= widen(tx_buffer_select);
               can_tx_pkg::OFS_IRQ_STATUS: wb_dat_o <= widen(irq_status_o);
               can_tx_pkg::OFS_IRQ_ENABLE: wb_dat_o <= widen(irq_enable);
               default:                    wb_dat_o <= can_tx_pkg::UNMAPPED_DATA;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** common/can_tx_pkg.sv ***
/*
 * Constants shared by the transmit abort / buffer-select block: register
 * offsets, field widths, reset values.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`default_nettype none
package can_tx_pkg;
   localparam int          NUM_BUF         = 3;
   localparam logic [7:0]  OFS_FLAG        = 8'h00;
   localparam logic [7:0]  OFS_IRQ_EN      = 8'h04;
   localparam logic [7:0]  OFS_ABORT_REQ   = 8'h08;
   localparam logic [7:0]  OFS_ABORT_ACK   = 8'h0c;
   localparam logic [7:0]  OFS_BUF_SEL     = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h14;
   localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h1c;
   localparam logic [2:0]  FLAG_RESET      = 3'h7;
   localparam logic [2:0]  ZERO_RESET      = 3'h0;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
endpackage
`default_nettype wire

// *** rtl/lowest_bit_pick.sv ***
/*
 * Keeps only the lowest set bit of a vector.
 * Pure combinational; no clock.
 */
`timescale 1ns/1ns
`default_nettype none
module lowest_bit_pick #(
   parameter int W = 3
) (
   input  wire logic [W-1:0] vec_i,   // Raw bits
   output logic      [W-1:0] pick_o   // Lowest set bit only
);
   always_comb begin
      pick_o = vec_i & (~vec_i + W'(1));
   end
endmodule
`default_nettype wire

// *** rtl/event_irq.sv ***
/*
 * Sticky event status, write-one clear and enable with one level interrupt.
 * Assumes synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module event_irq #(
   parameter int W = 3
) (
   input  wire logic         clk_i,    // Clock
   input  wire logic         rst_i,    // Sync reset
   input  wire logic [W-1:0] event_i,  // Event pulses
   input  wire logic [W-1:0] clear_i,  // One-cycle clear strobe per bit
   input  wire logic [W-1:0] enable_i, // Enable mask
   output logic      [W-1:0] status_o, // Sticky status
   output logic              irq_o     // Level interrupt
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else begin
         // Set beats clear so an event in the clear cycle survives
         status_o <= (status_o & ~clear_i) | event_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((status_o & ~clear_i) | event_i) & enable_i);
      end
   end
endmodule
`default_nettype wire

// *** sim/can_tx_abort_select_sva.sv ***
/*
 * Port-level checker for the transmit abort / buffer-select block.
 * Assumes single clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module can_tx_abort_select_sva #(
   parameter int NB = 3
) (
   input wire logic          clk_i,                 // Clock
   input wire logic          rst_i,                 // Sync reset
   input wire logic          wb_cyc_i,              // Cycle
   input wire logic          wb_stb_i,              // Strobe
   input wire logic          wb_we_i,               // Write
   input wire logic [7:0]    wb_adr_i,              // Address
   input wire logic          wb_ack_o,              // Acknowledge
   input wire logic          init_mode_request,     // Init request
   input wire logic          init_mode_acknowledge, // Init acknowledge
   input wire logic          win_req_i,             // Window request
   input wire logic          win_allow_o,           // Window permitted
   input wire logic [NB-1:0] win_buf_o,             // Selected buffer
   input wire logic [NB-1:0] scheduled_o,           // Queued buffers
   input wire logic [NB-1:0] irq_status_o,          // Sticky status
   input wire logic          irq_o                  // Interrupt
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_after_take:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_no_spurious_ack:
      assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_init_holds_regs:
      assert property ((init_mode_request && init_mode_acknowledge) [*3] |-> scheduled_o == '0 && win_buf_o == '0)
         else $error("registers not held in init");
   a_sel_one_hot:
      assert property ($onehot0(win_buf_o)) else $error("select not one-hot");
   a_win_gate:
      assert property (win_allow_o |-> $past(win_req_i) && win_buf_o != '0) else $error("window allowed wrongly");
   a_irq_cause:
      assert property (irq_o |-> irq_status_o != '0) else $error("interrupt without status");
   a_status_sticky:
      assert property (|($past(irq_status_o) & ~irq_status_o) |-> $past(init_mode_request && init_mode_acknowledge)
         || $past(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == can_tx_pkg::OFS_IRQ_CLEAR))
         else $error("status lost");
endmodule
bind can_tx_abort_select can_tx_abort_select_sva #(.NB(NB)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
   .init_mode_request(init_mode_request), .init_mode_acknowledge(init_mode_acknowledge),
   .win_req_i(win_req_i), .win_allow_o(win_allow_o), .win_buf_o(win_buf_o), .scheduled_o(scheduled_o),
   .irq_status_o(irq_status_o), .irq_o(irq_o));
`default_nettype wire

// *** sim/can_engine_model.sv ***
/*
 * Behavioural protocol engine: starts frames of queued buffers on request
 * and ends them with success or failure. Bench commands are one-cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module can_engine_model (
   input  wire logic       clk_i,     // Clock
   input  wire logic       rst_i,     // Sync reset
   input  wire logic [2:0] sched_i,   // Buffers queued
   input  wire logic [2:0] start_i,   // Start request
   input  wire logic [2:0] fin_i,     // End frames in flight
   input  wire logic       fail_i,    // End by error or lost arbitration
   output logic      [2:0] started_o, // Start pulse
   output logic      [2:0] done_o,    // Success pulse
   output logic      [2:0] failed_o   // Failure pulse
);
   logic [2:0] busy;
   // Only a queued, idle buffer may go on the bus
   always_ff @(posedge clk_i) begin
      started_o <= rst_i ? 3'h0 : start_i & sched_i & ~busy;
      done_o    <= rst_i ? 3'h0 : fin_i & busy & {3{~fail_i}};
      failed_o  <= rst_i ? 3'h0 : fin_i & busy & {3{fail_i}};
      busy      <= rst_i ? 3'h0 : (busy | started_o) & ~(done_o | failed_o);
   end
endmodule
`default_nettype wire

// *** sim/test_can_tx_abort_select.sv ***
/*
 * Register-level tests of the transmit abort / buffer-select block.
 * Assumes the behavioural engine model and the bound checker.
 */
`timescale 1ns/1ns
`default_nettype none
module test_can_tx_abort_select;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic        req   = 1'b0;
   logic        ir    = 1'b0;
   logic        ia    = 1'b0;
   logic        fail  = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic [2:0]  start = 3'h0;
   logic [2:0]  fin   = 3'h0;
   logic [31:0] rdq, rdat;
   logic [2:0]  st, dn, fl, wbuf, sch, ist;
   logic        ack, allow, irq;
   int          fail_count = 0;
   int          n_checks = 0;
   always #5 clk_i = ~clk_i;
   can_tx_abort_select i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdq), .wb_ack_o(ack),
      .init_mode_request(ir), .init_mode_acknowledge(ia), .tx_started_i(st), .tx_done_i(dn),
      .tx_failed_i(fl), .win_req_i(req), .win_allow_o(allow), .win_buf_o(wbuf), .scheduled_o(sch),
      .irq_status_o(ist), .irq_o(irq));
   can_engine_model i_eng (.clk_i(clk_i), .rst_i(rst_i), .sched_i(sch), .start_i(start), .fin_i(fin),
      .fail_i(fail), .started_o(st), .done_o(dn), .failed_o(fl));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = rdq;
      cyc <= 1'b0;
      chk({31'h0, ack}, 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic go(input logic [2:0] s, input logic [2:0] f, input logic e);
      @(posedge clk_i);
      start <= s;
      fin   <= f;
      fail  <= e;
      @(posedge clk_i);
      start <= 3'h0;
      fin   <= 3'h0;
   endtask
   task automatic win(input logic exp);
      @(posedge clk_i);
      req <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({31'h0, allow}, {31'h0, exp});
      req <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic test_done();
      $display("Checks %0d, errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(can_tx_pkg::OFS_FLAG, 32'h7);
      rd(8'h20, 32'h0);
      win(1'b0);
      bus(1'b1, can_tx_pkg::OFS_FLAG, 32'h1);
      bus(1'b1, can_tx_pkg::OFS_BUF_SEL, 32'h6);
      rd(can_tx_pkg::OFS_BUF_SEL, 32'h2);
      chk({29'h0, sch}, 32'h1);
      win(1'b1);
      bus(1'b1, can_tx_pkg::OFS_BUF_SEL, 32'h7);
      win(1'b0);
      chk({29'h0, wbuf}, 32'h1);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h2);
      rd(can_tx_pkg::OFS_ABORT_REQ, 32'h0);
      bus(1'b1, can_tx_pkg::OFS_IRQ_EN, 32'h7);
      bus(1'b1, can_tx_pkg::OFS_IRQ_ENABLE, 32'h0);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h1);
      rd(can_tx_pkg::OFS_FLAG, 32'h7);
      rd(can_tx_pkg::OFS_ABORT_REQ, 32'h0);
      rd(can_tx_pkg::OFS_IRQ_STATUS, 32'h1);
      chk({29'h0, ist}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, can_tx_pkg::OFS_IRQ_ENABLE, 32'h7);
      bus(1'b1, can_tx_pkg::OFS_ABORT_ACK, 32'h0);
      rd(can_tx_pkg::OFS_ABORT_ACK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, can_tx_pkg::OFS_IRQ_CLEAR, 32'h1);
      rd(can_tx_pkg::OFS_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, can_tx_pkg::OFS_FLAG, 32'h1);
      rd(can_tx_pkg::OFS_ABORT_ACK, 32'h0);
      go(3'h1, 3'h0, 1'b0);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h1);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h0);
      rd(can_tx_pkg::OFS_ABORT_REQ, 32'h1);
      rd(can_tx_pkg::OFS_FLAG, 32'h6);
      go(3'h0, 3'h1, 1'b0);
      rd(can_tx_pkg::OFS_ABORT_REQ, 32'h0);
      rd(can_tx_pkg::OFS_ABORT_ACK, 32'h0);
      bus(1'b1, can_tx_pkg::OFS_FLAG, 32'h1);
      go(3'h1, 3'h0, 1'b0);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h1);
      go(3'h0, 3'h1, 1'b1);
      // Grant comes one cycle after the failure pulse, once the in-flight mark has cleared
      @(posedge clk_i);
      rd(can_tx_pkg::OFS_ABORT_ACK, 32'h1);
      rd(can_tx_pkg::OFS_FLAG, 32'h7);
      bus(1'b1, can_tx_pkg::OFS_FLAG, 32'h2);
      go(3'h2, 3'h0, 1'b0);
      bus(1'b1, can_tx_pkg::OFS_ABORT_REQ, 32'h2);
      bus(1'b1, can_tx_pkg::OFS_IRQ_CLEAR, 32'h7);
      @(posedge clk_i);
      ir <= 1'b1;
      ia <= 1'b1;
      bus(1'b1, can_tx_pkg::OFS_BUF_SEL, 32'h4);
      rd(can_tx_pkg::OFS_ABORT_REQ, 32'h0);
      rd(can_tx_pkg::OFS_ABORT_ACK, 32'h0);
      @(posedge clk_i);
      ir <= 1'b0;
      ia <= 1'b0;
      rd(can_tx_pkg::OFS_BUF_SEL, 32'h0);
      test_done();
   end
   // Whole run needs under two hundred cycles
   initial begin
      #100000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
